//--- sfe_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sfe_fifo import sfe_pkg::*; #(
  parameter int unsigned WIDTH = BYTE_W,
  parameter int unsigned DEPTH = TX_FIFO_DEPTH
) (
  input wire logic clk, // Core clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] in_data, // Write word
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  output logic [WIDTH-1:0] out_data, // Head word
  output logic out_valid, // Head word present
  input wire logic out_ready // Head word taken
);

  // ------------------------------------------------------------
  // Pointers carry one wrap bit; DEPTH must be a power of two
  // ------------------------------------------------------------
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] PTR_ONE = {{AW{1'b0}}, 1'b1};
  localparam logic [AW:0] PTR_ZERO = '0;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic push, pop, full, empty;

  always_comb begin
    full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    empty = (wr_r == rd_r);
    in_ready = !full;
    out_valid = !empty;
    push = in_valid && !full;
    pop = out_ready && !empty;
    wr_nxt = push ? wr_r + PTR_ONE : wr_r;
    rd_nxt = pop ? rd_r + PTR_ONE : rd_r;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_r <= PTR_ZERO;
      rd_r <= PTR_ZERO;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Storage is not reset: only the pointers define its contents
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_data;
    end
  end

  assign out_data = mem_r[rd_r[AW-1:0]];

endmodule // sfe_fifo
`default_nettype wire

//--- sfe_front_end.sv
// Summary of operation
// - On shared-pin parts a select bit makes the IO3 pin pause or restart.
// - Dedicated-restart variants treat IO3 as pause only, ignoring the select bit.
// - Dedicated-restart variants disable their restart pin when the disable bit is one.
// - While select is high the device is deselected and floats its output.
// - Deselected means standby; select low leaves standby and enables transfers.
// - No instruction is taken until select has gone high then low after power-up; the synchroniser resets select high, so a low held through reset is taken.
// - All serial input is ignored while select is high.
// - The input line is sampled on each rising serial clock edge.
// - The output line changes on the falling serial clock edge.
// - Pause low while selected floats output and freezes the sequence until released.
// - Select bit zero means pause function, one means hardware restart function.
// - Quad lane enable drops write-guard and pause/restart pin functions.
// - Restart low holds the device in reset with outputs floated.
`timescale 1ns/10ps
`default_nettype none
module sfe_front_end import sfe_pkg::*; #(
  parameter bit HAS_DEDICATED_RESTART = 1'b0,
  parameter int unsigned FIFO_DEPTH = TX_FIFO_DEPTH
) (
  input wire logic core_clk, // 20 MHz core clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic sck_pin, // Serial clock from host
  input wire logic cs_n_pin, // Select from host, active low
  input wire logic si_pin, // Serial data in
  input wire logic data_lane_2, // Write guard input, active low
  input wire logic data_lane_3, // Pause or restart input, active low
  input wire logic restart_n_pin, // Dedicated restart input, active low
  input wire logic io3_function_select, // 0 pause, 1 restart
  input wire logic quad_lane_enable, // Lanes 2 and 3 carry data
  input wire logic restart_pin_disable, // 1 disables dedicated restart pin
  input wire logic [BYTE_W-1:0] tx_data, // Byte to shift out
  input wire logic tx_valid, // Byte offered
  output logic tx_ready, // Transmit buffer has room
  output logic [BYTE_W-1:0] rx_data, // Last received byte
  output logic rx_valid, // One cycle pulse per received byte
  output logic so_o, // Serial data out level
  output logic so_oe, // Serial data out enable
  output var sfe_status_type status // Registered status flags
);

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  sfe_pins_type pins_raw;
  sfe_pins_type pins_s;

  assign pins_raw = '{sck: sck_pin, cs_n: cs_n_pin, si: si_pin, lane2: data_lane_2,
                      lane3: data_lane_3, rst_n: restart_n_pin};

  sfe_sync #(
    .WIDTH($bits(sfe_pins_type)),
    .RESET_VAL(PINS_IDLE)
  ) u_sync (
    .clk(core_clk),
    .resetn(resetn),
    .d_in(pins_raw),
    .q_out(pins_s)
  );

  // ------------------------------------------------------------
  // Pin function selection
  // ------------------------------------------------------------
  logic io3_restart_fn, hold_fn, ded_restart_en;
  logic restart_req, pause_req, guard_req;

  always_comb begin
    io3_restart_fn = !quad_lane_enable && !HAS_DEDICATED_RESTART
                     && (io3_function_select == IO3_FN_RESTART);
    hold_fn = !quad_lane_enable && !io3_restart_fn;
    ded_restart_en = HAS_DEDICATED_RESTART && (restart_pin_disable == RST_PIN_ENABLED);
    restart_req = (io3_restart_fn && !pins_s.lane3) || (ded_restart_en && !pins_s.rst_n);
    pause_req = hold_fn && !pins_s.lane3 && !pins_s.cs_n;
    guard_req = !quad_lane_enable && !pins_s.lane2;
  end

  // ------------------------------------------------------------
  // Select state machine
  // ------------------------------------------------------------
  // Leaving WAIT needs select seen high, so a select held low through
  // a restart never counts as a falling transition.
  sfe_state_type state_r, state_nxt;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_WAIT: begin
        if (pins_s.cs_n) begin
          state_nxt = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (!pins_s.cs_n) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (pins_s.cs_n) begin
          state_nxt = ST_STANDBY;
        end else if (pause_req) begin
          state_nxt = ST_PAUSED;
        end
      end
      ST_PAUSED: begin
        if (pins_s.cs_n) begin
          state_nxt = ST_STANDBY;
        end else if (!pause_req) begin
          state_nxt = ST_ACTIVE;
        end
      end
    endcase
    if (restart_req) begin
      state_nxt = ST_WAIT;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_r <= ST_WAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // Serial clock edges and shift registers
  // ------------------------------------------------------------
  logic sck_prev_r, sck_prev_nxt;
  logic sck_rise, sck_fall, shift_ok, enter, load_go;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic rise_seen_r, rise_seen_nxt;
  logic [BYTE_W-1:0] rx_sr_r, rx_sr_nxt, rx_data_r, rx_data_nxt;
  logic rx_valid_r, rx_valid_nxt;
  logic [BYTE_W-1:0] tx_sr_r, tx_sr_nxt;
  logic [BYTE_W-1:0] fifo_data;
  logic fifo_valid;

  always_comb begin
    sck_prev_nxt = pins_s.sck;
    sck_rise = pins_s.sck && !sck_prev_r;
    sck_fall = !pins_s.sck && sck_prev_r;
    shift_ok = (state_r == ST_ACTIVE) && !pins_s.cs_n && !pause_req && !restart_req;
    enter = (state_r == ST_STANDBY) && !pins_s.cs_n && !restart_req;
    rx_sr_nxt = rx_sr_r;
    rx_data_nxt = rx_data_r;
    rx_valid_nxt = 1'b0;
    tx_sr_nxt = tx_sr_r;
    bit_cnt_nxt = bit_cnt_r;
    rise_seen_nxt = rise_seen_r;
    load_go = 1'b0;
    if (restart_req || pins_s.cs_n) begin
      bit_cnt_nxt = BIT_FIRST;
      rise_seen_nxt = 1'b0;
    end else if (enter) begin
      load_go = 1'b1;
      bit_cnt_nxt = BIT_FIRST;
      rise_seen_nxt = 1'b0;
    end else if (shift_ok) begin
      if (sck_rise) begin
        rx_sr_nxt = {rx_sr_r[BYTE_W-2:0], pins_s.si};
        bit_cnt_nxt = bit_cnt_r + BIT_STEP;
        rise_seen_nxt = 1'b1;
        if (bit_cnt_r == BIT_LAST) begin
          rx_data_nxt = {rx_sr_r[BYTE_W-2:0], pins_s.si};
          rx_valid_nxt = 1'b1;
        end
      end else if (sck_fall && rise_seen_r) begin
        // The falling edge after the eighth rising edge loads the next byte; it must not shift
        if (bit_cnt_r == BIT_FIRST) begin
          load_go = 1'b1;
        end else begin
          tx_sr_nxt = {tx_sr_r[BYTE_W-2:0], TX_SHIFT_IN};
        end
      end
    end
    if (load_go) begin
      // An empty buffer cannot stall the host clock, so idle ones go out
      tx_sr_nxt = fifo_valid ? fifo_data : TX_FILL;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sck_prev_r <= 1'b0;
      bit_cnt_r <= BIT_FIRST;
      rise_seen_r <= 1'b0;
      rx_sr_r <= RX_RESET;
      rx_data_r <= RX_RESET;
      rx_valid_r <= 1'b0;
      tx_sr_r <= TX_FILL;
    end else begin
      sck_prev_r <= sck_prev_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      rise_seen_r <= rise_seen_nxt;
      rx_sr_r <= rx_sr_nxt;
      rx_data_r <= rx_data_nxt;
      rx_valid_r <= rx_valid_nxt;
      tx_sr_r <= tx_sr_nxt;
    end
  end

  // ------------------------------------------------------------
  // Transmit buffer
  // ------------------------------------------------------------
  sfe_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(core_clk),
    .resetn(resetn),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(load_go)
  );

  // ------------------------------------------------------------
  // Outputs and status
  // ------------------------------------------------------------
  sfe_status_type status_r, status_nxt;

  always_comb begin
    status_nxt = '{standby: pins_s.cs_n, armed: (state_r != ST_WAIT),
                   paused: (state_r == ST_PAUSED), in_reset: restart_req,
                   write_guard: guard_req};
    so_oe = (state_r == ST_ACTIVE) && !pins_s.cs_n && !pause_req && !restart_req;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      status_r <= STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign status = status_r;
  assign so_o = tx_sr_r[BYTE_W-1];
  assign rx_data = rx_data_r;
  assign rx_valid = rx_valid_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_io3_select_restart: assert property (
    (!HAS_DEDICATED_RESTART && !quad_lane_enable && io3_function_select
     && !pins_s.lane3) |-> restart_req && !pause_req)
    else $error("IO3 low with restart selected did not restart");

  a_io3_select_pause: assert property (
    (!quad_lane_enable && !io3_function_select && !pins_s.lane3 && !pins_s.cs_n)
    |-> pause_req && !io3_restart_fn)
    else $error("IO3 low with pause selected did not pause");

  a_ded_pause_only: assert property (
    (HAS_DEDICATED_RESTART && !quad_lane_enable) |-> hold_fn && !io3_restart_fn)
    else $error("dedicated variant used IO3 as restart");

  a_ded_pin_disable: assert property (
    (HAS_DEDICATED_RESTART && restart_pin_disable && !pins_s.rst_n && !io3_restart_fn)
    |-> !restart_req)
    else $error("disabled restart pin still restarted");

  a_desel_float: assert property (
    pins_s.cs_n |-> !so_oe)
    else $error("output driven while deselected");

  a_standby_flag: assert property (
    pins_s.cs_n |=> status_r.standby ##1 (status_r.standby || $past(!pins_s.cs_n)))
    else $error("standby flag not shown while deselected");

  a_wait_first_fall: assert property (
    (state_r == ST_WAIT && !pins_s.cs_n) |=> state_r == ST_WAIT && !rx_valid_r)
    else $error("left wait without select going high");

  a_ignore_desel: assert property (
    pins_s.cs_n |=> $stable(rx_sr_r) && !rx_valid_r)
    else $error("serial input taken while deselected");

  a_rise_sample: assert property (
    (shift_ok && sck_rise) |=> rx_sr_r[0] == $past(pins_s.si)
                              && rx_sr_r[BYTE_W-1:1] == $past(rx_sr_r[BYTE_W-2:0]))
    else $error("input not shifted on rising edge");

  a_fall_launch: assert property (
    $changed(tx_sr_r) |-> $past(load_go) || $past(shift_ok && sck_fall))
    else $error("output changed off a falling edge");

  a_pause_freeze: assert property (
    (state_r == ST_PAUSED && !restart_req && !pins_s.cs_n)
    |-> !so_oe ##1 $stable(bit_cnt_r) && $stable(rx_sr_r))
    else $error("sequence moved while paused");

  a_quad_lanes: assert property (
    quad_lane_enable |-> !hold_fn && !io3_restart_fn && !guard_req && !pause_req)
    else $error("pin function active with quad lanes on");

  a_restart_float: assert property (
    restart_req |-> !so_oe ##1 (state_r == ST_WAIT) && (bit_cnt_r == BIT_FIRST))
    else $error("restart did not float outputs and clear state");

endmodule // sfe_front_end
`default_nettype wire

//--- sfe_front_end_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sfe_front_end_tb import sfe_pkg::*;;
  logic core_clk, resetn, lane2, lane3, rst_pin, fn_sel, quad, rst_dis, tx_valid, s;
  logic [7:0] tx_data, rb;
  logic tx_ready, rx_valid, so_o, so_oe, sck, cs_n, si;
  logic [7:0] rx_data;
  sfe_status_type status;
  wire so_line;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [7:0] rxq[$];
  logic [7:0] tq[$];
  logic [7:0] eq[$];

  assign so_line = so_oe ? so_o : 1'bz;

  sfe_front_end DUT (.core_clk(core_clk), .resetn(resetn), .sck_pin(sck), .cs_n_pin(cs_n),
    .si_pin(si), .data_lane_2(lane2), .data_lane_3(lane3), .restart_n_pin(rst_pin),
    .io3_function_select(fn_sel), .quad_lane_enable(quad), .restart_pin_disable(rst_dis),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .so_o(so_o), .so_oe(so_oe), .status(status));

  sfe_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so_line));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_data);
    end
  end

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  function automatic logic [7:0] fv(input int i);
    return 8'h10 ^ 8'(i * 17);
  endfunction

  // Offers n bytes back to back; anything past the buffer depth is refused
  task automatic fill(input int n);
    @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      tx_data <= fv(i);
      tx_valid <= 1'b1;
      @(posedge core_clk);
    end
    tx_valid <= 1'b0;
  endtask

  task automatic xfer();
    rxq = {};
    host.sel();
    foreach (tq[i]) begin
      host.byte_x(tq[i], rb);
      chk(rb, eq[i]);
      chk(so_oe, 1'b1);
    end
    host.desel();
    chk(so_line, 1'bz);
    chk(status.standby, 1'b1);
    chk(8'(rxq.size()), 8'(tq.size()));
    foreach (tq[i]) begin
      chk(rxq[i], tq[i]);
    end
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    test_done();
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    resetn = 1'b0;
    lane2 = 1'b1;
    lane3 = 1'b1;
    rst_pin = 1'b1;
    fn_sel = 1'b0;
    quad = 1'b0;
    rst_dis = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    cyc(6);
    #1;
    chk(so_oe, 1'b0);
    chk(rx_valid, 1'b0);
    chk(rx_data, 8'h00);
    chk(tx_ready, 1'b1);
    chk(status, STATUS_RESET);
    @(posedge core_clk);
    resetn <= 1'b1;
    cyc(6);
    $display("test reset done");

    fill(2);
    tq = '{8'h96, 8'h5a, 8'hc3};
    eq = '{fv(0), fv(1), 8'hff};
    xfer();
    $display("test transfer done");

    fill(17);
    #1;
    chk(tx_ready, 1'b0);
    tq = {};
    eq = {};
    for (int i = 0; i < 17; i++) begin
      tq.push_back(8'(i * 13));
      eq.push_back(i < 16 ? fv(i) : 8'hff);
    end
    xfer();
    chk(tx_ready, 1'b1);
    $display("test buffer done");

    rxq = {};
    host.sel();
    for (int i = 7; i >= 4; i--) begin
      host.bit_x(i[0] ^ i[1], s);
    end
    cyc(4);
    lane3 <= 1'b0;
    cyc(4);
    #1;
    chk(so_oe, 1'b0);
    chk(status.paused, 1'b1);
    host.bit_x(1'b0, s);
    host.bit_x(1'b1, s);
    @(posedge core_clk);
    lane3 <= 1'b1;
    cyc(4);
    for (int i = 3; i >= 0; i--) begin
      host.bit_x(i[0] ^ i[1], s);
      chk(s, 1'b1);
    end
    host.desel();
    chk(8'(rxq.size()), 8'h01);
    chk(rxq[0], 8'h66);
    $display("test pause done");

    rxq = {};
    @(posedge core_clk);
    fn_sel <= 1'b1;
    host.sel();
    @(posedge core_clk);
    lane3 <= 1'b0;
    cyc(4);
    #1;
    chk(status.in_reset, 1'b1);
    chk(so_oe, 1'b0);
    @(posedge core_clk);
    lane3 <= 1'b1;
    cyc(4);
    chk(status.armed, 1'b0);
    host.byte_x(8'h3c, rb);
    host.desel();
    chk(8'(rxq.size()), 8'h00);
    chk(status.armed, 1'b1);
    fn_sel <= 1'b0;
    tq = '{8'h81};
    eq = '{8'hff};
    xfer();
    $display("test restart done");

    @(posedge core_clk);
    quad <= 1'b1;
    lane2 <= 1'b0;
    lane3 <= 1'b0;
    cyc(4);
    chk(status.write_guard, 1'b0);
    host.sel();
    for (int i = 0; i < 3; i++) begin
      host.bit_x(1'b1, s);
    end
    host.desel();
    tq = '{8'he7};
    xfer();
    chk(status.paused, 1'b0);
    @(posedge core_clk);
    quad <= 1'b0;
    cyc(4);
    chk(status.write_guard, 1'b1);
    lane2 <= 1'b1;
    lane3 <= 1'b1;
    cyc(4);
    $display("test lane enable done");
    test_done();
  end
endmodule // sfe_front_end_tb
`default_nettype wire

//--- sfe_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module sfe_host_model (
  output logic sck, // Serial clock, idle low between frames
  output logic cs_n, // Select, active low
  output logic si, // Serial data to device
  input wire logic so // Serial data from device, Z when floated
);
  localparam int HALF = 200;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // Offset keeps host edges away from core clock edges
  task automatic sel();
    #13;
    cs_n = 1'b0;
    #(HALF);
  endtask

  task automatic desel();
    #(HALF);
    cs_n = 1'b1;
    si = ~si; // Released line must not look like valid data
    #(HALF);
  endtask

  // Mode 0 bit; so is read late in the high phase, still before the next launch
  task automatic bit_x(input logic b, output logic s);
    si = b;
    #(HALF);
    sck = 1'b1;
    #(HALF - 10);
    s = so;
    #10;
    sck = 1'b0;
  endtask

  task automatic byte_x(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bit_x(t[i], r[i]);
    end
  endtask
endmodule // sfe_host_model
`default_nettype wire

//--- sfe_pkg.sv
`default_nettype none
package sfe_pkg;

  // ------------------------------------------------------------
  // Data path widths and depths
  // ------------------------------------------------------------
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned TX_FIFO_DEPTH = 16;
  localparam int unsigned SYNC_STAGES = 2;

  // ------------------------------------------------------------
  // Bit counter and fill values
  // ------------------------------------------------------------
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam logic [7:0] TX_FILL = 8'hff;
  localparam logic [7:0] RX_RESET = 8'h00;
  localparam logic TX_SHIFT_IN = 1'b1;

  // ------------------------------------------------------------
  // Pin function encodings
  // ------------------------------------------------------------
  localparam logic IO3_FN_PAUSE = 1'b0;
  localparam logic IO3_FN_RESTART = 1'b1;
  localparam logic RST_PIN_ENABLED = 1'b0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic lane2;
    logic lane3;
    logic rst_n;
  } sfe_pins_type;

  localparam sfe_pins_type PINS_IDLE = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0,
                                         lane2: 1'b1, lane3: 1'b1, rst_n: 1'b1};

  typedef enum logic [1:0] {
    ST_WAIT = 2'h0,
    ST_STANDBY = 2'h1,
    ST_ACTIVE = 2'h3,
    ST_PAUSED = 2'h2
  } sfe_state_type;

  typedef struct packed {
    logic standby;
    logic armed;
    logic paused;
    logic in_reset;
    logic write_guard;
  } sfe_status_type;

  localparam sfe_status_type STATUS_RESET = '{standby: 1'b1, armed: 1'b0, paused: 1'b0,
                                              in_reset: 1'b0, write_guard: 1'b0};

endpackage
`default_nettype wire

//--- sfe_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sfe_sync import sfe_pkg::*; #(
  parameter int unsigned WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk, // Core clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] d_in, // Asynchronous pin levels
  output logic [WIDTH-1:0] q_out // Synchronised levels
);

  // ------------------------------------------------------------
  // Two flop synchroniser, first stage feeds only the second
  // ------------------------------------------------------------
  logic [WIDTH-1:0] meta_r, meta_nxt;
  logic [WIDTH-1:0] sync_r, sync_nxt;

  always_comb begin
    meta_nxt = d_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign q_out = sync_r;

endmodule // sfe_sync
`default_nettype wire
